// File: ims_pkg.sv
package ims_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned FAST_BPS = 400_000;
    localparam int unsigned STD_BPS = 100_000;
    // Quarter bit periods round up so the bus never runs faster than its class.
    localparam int unsigned QTR_FAST = (CLK_HZ + 4 * FAST_BPS - 1) / (4 * FAST_BPS);
    localparam int unsigned QTR_STD = (CLK_HZ + 4 * STD_BPS - 1) / (4 * STD_BPS);
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(QTR_FAST - 1);
    localparam logic [DIV_W-1:0] DIV_STD = DIV_W'(QTR_STD - 1);
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MADDR = 8'h04;
    localparam logic [7:0] OFF_MDATA = 8'h08;
    localparam logic [7:0] OFF_MCMD = 8'h0c;
    localparam logic [7:0] OFF_MSTAT = 8'h10;
    localparam logic [7:0] OFF_SADDR = 8'h14;
    localparam logic [7:0] OFF_SDATA = 8'h18;
    localparam logic [7:0] OFF_SSTAT = 8'h1c;
    localparam logic [7:0] OFF_INTST = 8'h20;
    localparam logic [7:0] OFF_INTMASK = 8'h24;
    localparam int CTRL_MEN = 0;
    localparam int CTRL_SEN = 1;
    localparam int CTRL_FAST = 2;
    localparam int CTRL_MSEL = 3;
    localparam int MADDR_RD = 7;
    localparam int MCMD_GO = 0;
    localparam int INT_MST = 0;
    localparam int INT_SLV = 1;
    localparam logic [3:0] RST_CTRL = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] RST_OWN = 7'h00;
    localparam logic [1:0] RST_INT = 2'h0;
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_ADDR_ACK = 2'h1;
    localparam logic [1:0] ERR_DATA_ACK = 2'h2;
    localparam logic [1:0] err_code_arbitration_lost = 2'h3;
    localparam logic [1:0] slave_req_idle = 2'h0;
    localparam logic [1:0] slave_req_receive = 2'h1;
    localparam logic [1:0] slave_req_transmit = 2'h2;
    localparam logic [1:0] slave_req_first_byte = 2'h3;
    typedef enum logic [1:0] {M_IDLE, M_START, M_BITS, M_STOP} ims_mstate_e;
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_TXACK} ims_sstate_e;
endpackage

// File: ims_i2c_port.sv
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module ims_i2c_port (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic irq
);
    import ims_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    logic sclS1_reg, sclS2_reg, sclS3_reg, sdaS1_reg, sdaS2_reg, sdaS3_reg;
    logic dPend_reg, dWrite_reg, hreadyout_reg, pinLow_reg, irq_reg;
    logic sclOe_reg, sdaOe_reg;
    logic [7:0] dAddr_reg;
    logic [31:0] hrdata_reg, rdData;
    logic [3:0] ctrl_reg;
    logic [7:0] mAddr_reg, mTx_reg, mRx_reg, mShift_reg, sShift_reg, sRx_reg, sTx_reg;
    logic [6:0] sOwn_reg;
    logic [1:0] mErr_reg, mPhase_reg, sReq_reg, intRaw_reg, intMask_reg;
    logic [1:0] intW1c, intShow;
    logic [DIV_W-1:0] mDiv_reg, divLoad;
    logic [3:0] mBit_reg;
    logic [2:0] sBit_reg;
    logic mByte_reg, mSample_reg, mBusyD_reg, busBusy_reg;
    logic sDrive_reg, sRd_reg, sFirst_reg;
    ims_mstate_e mState_reg;
    ims_sstate_e sState_reg;

    // Only the second and third stages are looked at; the first is metastable.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            {sclS1_reg, sclS2_reg, sclS3_reg} <= 3'h7;
            {sdaS1_reg, sdaS2_reg, sdaS3_reg} <= 3'h7;
        end else begin
            sclS1_reg <= sclIn;
            sclS2_reg <= sclS1_reg;
            sclS3_reg <= sclS2_reg;
            sdaS1_reg <= sdaIn;
            sdaS2_reg <= sdaS1_reg;
            sdaS3_reg <= sdaS2_reg;
        end
    end

    wire sclRise = sclS2_reg & ~sclS3_reg;
    wire sclFall = ~sclS2_reg & sclS3_reg;
    wire startSeen = sclS2_reg & sclS3_reg & sdaS3_reg & ~sdaS2_reg;
    wire stopSeen = sclS2_reg & sclS3_reg & ~sdaS3_reg & sdaS2_reg;

    // Every transfer takes one wait state so read data always come from a flop.
    wire accept = hsel & htrans[1] & hready;
    wire wrEn = dPend_reg & dWrite_reg;

    function automatic logic hit(input logic [7:0] off);
        return dAddr_reg == off;
    endfunction

    function automatic logic wr(input logic [7:0] off);
        return wrEn && hit(off);
    endfunction

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dPend_reg <= 1'b0;
            dWrite_reg <= 1'b0;
            dAddr_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h0;
        end else begin
            dPend_reg <= accept;
            hreadyout_reg <= ~accept;
            if (accept) begin
                dAddr_reg <= haddr[7:0];
                dWrite_reg <= hwrite;
            end
            if (dPend_reg && !dWrite_reg) begin
                hrdata_reg <= rdData;
            end
        end
    end

    sequence s_one_wait;
        !hreadyout_reg ##1 hreadyout_reg;
    endsequence
    property p_ahb_wait;
        accept |=> s_one_wait;
    endproperty
    a_ahb_wait: assert property (p_ahb_wait) else $error("AHB wait state wrong.");

    wire mBusy = mState_reg != M_IDLE;
    wire mDone = mBusyD_reg & ~mBusy;
    wire rxByte = mByte_reg & mAddr_reg[MADDR_RD];
    wire mGo = wr(OFF_MCMD) & hwdata[MCMD_GO] & ctrl_reg[CTRL_MEN] & ~mBusy & ~busBusy_reg;
    assign intShow = ctrl_reg[CTRL_MSEL] ? (intRaw_reg & intMask_reg) : intRaw_reg;
    assign intW1c = wr(OFF_INTST) ? hwdata[1:0] : 2'h0;
    wire intPend = |(intRaw_reg & intMask_reg);

    assign rdData =
        hit(OFF_CTRL) ? {28'h0, ctrl_reg} :
        hit(OFF_MADDR) ? {24'h0, mAddr_reg} :
        hit(OFF_MDATA) ? {24'h0, mRx_reg} :
        hit(OFF_MSTAT) ? {28'h0, busBusy_reg, mBusy, mErr_reg} :
        hit(OFF_SADDR) ? {25'h0, sOwn_reg} :
        hit(OFF_SDATA) ? {24'h0, sRx_reg} :
        hit(OFF_SSTAT) ? {30'h0, sReq_reg} :
        hit(OFF_INTST) ? {30'h0, intShow} :
        hit(OFF_INTMASK) ? {30'h0, intMask_reg} : 32'h0;

    // Master bit engine: four quarter periods per bit, counted on the system clock.
    assign divLoad = ctrl_reg[CTRL_FAST] ? DIV_FAST : DIV_STD;
    wire mTick = mDiv_reg == '0;
    // A slave holding the clock low stretches the high quarter.
    wire mStall = (mState_reg == M_BITS) && (mPhase_reg == 2'h1) && !sclS2_reg;
    wire sendBit = rxByte | mBit_reg[3] | mShift_reg[7];
    wire mArb = ctrl_reg[CTRL_MEN] && !mGo && mState_reg == M_BITS && mTick && !mStall
        && mPhase_reg == 2'h3 && !mBit_reg[3] && sendBit && !mSample_reg && !rxByte;
    wire mScl = (mState_reg == M_START && mPhase_reg == 2'h3)
        || (mState_reg == M_BITS && (mPhase_reg == 2'h0 || mPhase_reg == 2'h3))
        || (mState_reg == M_STOP && mPhase_reg == 2'h0);
    wire mSda = (mState_reg == M_START && mPhase_reg != 2'h0)
        || (mState_reg == M_BITS && !sendBit)
        || (mState_reg == M_STOP && mPhase_reg != 2'h3);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mState_reg <= M_IDLE;
            mPhase_reg <= 2'h0;
            mDiv_reg <= '0;
            mBit_reg <= 4'h0;
            mByte_reg <= 1'b0;
            mShift_reg <= RST_BYTE;
            mSample_reg <= 1'b1;
            mErr_reg <= ERR_NONE;
            mRx_reg <= RST_BYTE;
        end else if (!ctrl_reg[CTRL_MEN]) begin
            mState_reg <= M_IDLE;
        end else if (mGo) begin
            mState_reg <= M_START;
            mPhase_reg <= 2'h0;
            mDiv_reg <= divLoad;
            mBit_reg <= 4'h0;
            mByte_reg <= 1'b0;
            mShift_reg <= {mAddr_reg[6:0], mAddr_reg[MADDR_RD]};
            mErr_reg <= ERR_NONE;
        end else if (mBusy) begin
            mDiv_reg <= mTick ? (mStall ? mDiv_reg : divLoad) : mDiv_reg - 1'b1;
            if (mTick && !mStall) begin
                mPhase_reg <= mPhase_reg + 2'h1;
                if (mPhase_reg == 2'h2) begin
                    mSample_reg <= sdaS2_reg;
                end
                if (mPhase_reg == 2'h3) begin
                    case (mState_reg)
                        M_START: mState_reg <= M_BITS;
                        M_BITS: begin
                            if (!mBit_reg[3]) begin
                                if (mArb) begin
                                    mErr_reg <= err_code_arbitration_lost;
                                    mState_reg <= M_IDLE;
                                end
                                mBit_reg <= mBit_reg + 4'h1;
                                mShift_reg <= {mShift_reg[6:0], mSample_reg};
                            end else if (!mByte_reg) begin
                                if (mSample_reg) begin
                                    mErr_reg <= ERR_ADDR_ACK;
                                    mState_reg <= M_STOP;
                                end
                                mByte_reg <= 1'b1;
                                mBit_reg <= 4'h0;
                                mShift_reg <= mTx_reg;
                            end else begin
                                if (rxByte) begin
                                    mRx_reg <= mShift_reg;
                                end else if (mSample_reg) begin
                                    mErr_reg <= ERR_DATA_ACK;
                                end
                                mState_reg <= M_STOP;
                            end
                        end
                        M_STOP: mState_reg <= M_IDLE;
                        default: mState_reg <= M_IDLE;
                    endcase
                end
            end
        end
    end

    property p_start_load;
        mGo |=> mState_reg == M_START && mShift_reg == {mAddr_reg[6:0], mAddr_reg[MADDR_RD]};
    endproperty
    a_start_load: assert property (p_start_load) else $error("Address byte not loaded.");
    property p_busy;
        mGo |=> mBusy;
    endproperty
    a_busy: assert property (p_busy) else $error("Busy not set on start.");
    property p_fast_div;
        (mBusy && mTick && !mStall && ctrl_reg[CTRL_FAST] && ctrl_reg[CTRL_MEN] && !mGo)
            |=> mDiv_reg == DIV_FAST;
    endproperty
    a_fast_div: assert property (p_fast_div) else $error("Fast divider wrong.");
    property p_std_div;
        (mBusy && mTick && !mStall && !ctrl_reg[CTRL_FAST] && ctrl_reg[CTRL_MEN] && !mGo)
            |=> mDiv_reg == DIV_STD;
    endproperty
    a_std_div: assert property (p_std_div) else $error("Standard divider wrong.");
    property p_err_arb;
        mArb |=> mErr_reg == err_code_arbitration_lost && !mBusy;
    endproperty
    a_err_arb: assert property (p_err_arb) else $error("Arbitration loss not reported.");
    property p_men_off;
        !ctrl_reg[CTRL_MEN] |=> !mBusy ##1 !sclOe_reg;
    endproperty
    a_men_off: assert property (p_men_off) else $error("Master runs while disabled.");

    // Slave engine: follows the synchronised lines, no clock stretching.
    wire sAct = ctrl_reg[CTRL_SEN] & ~stopSeen & ~startSeen;
    wire [7:0] sByteIn = {sShift_reg[6:0], sdaS2_reg};
    wire sGotByte = sAct & (sState_reg == S_RX) & sclRise & (sBit_reg == 3'h7);
    wire sAddrRd = sAct & (sState_reg == S_ADDR) & sclRise & (sBit_reg == 3'h7)
        & (sByteIn[7:1] == sOwn_reg) & sByteIn[0];
    wire sAckRd = sAct & (sState_reg == S_TXACK) & sclRise & ~sclFall & ~sdaS2_reg;
    wire sTxReq = sAddrRd | sAckRd;
    wire sEvent = sGotByte | sTxReq;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sState_reg <= S_IDLE;
            sDrive_reg <= 1'b0;
            sBit_reg <= 3'h0;
            sShift_reg <= RST_BYTE;
            sRd_reg <= 1'b0;
            sFirst_reg <= 1'b0;
        end else if (!ctrl_reg[CTRL_SEN] || stopSeen) begin
            sState_reg <= S_IDLE;
            sDrive_reg <= 1'b0;
        end else if (startSeen) begin
            sState_reg <= S_ADDR;
            sBit_reg <= 3'h0;
            sDrive_reg <= 1'b0;
        end else begin
            case (sState_reg)
                S_ADDR: if (sclRise) begin
                    sShift_reg <= sByteIn;
                    sBit_reg <= sBit_reg + 3'h1;
                    if (sBit_reg == 3'h7) begin
                        sState_reg <= (sByteIn[7:1] == sOwn_reg) ? S_ACK : S_IDLE;
                        sRd_reg <= sByteIn[0];
                        sFirst_reg <= 1'b1;
                    end
                end
                S_ACK: if (sclFall) begin
                    sDrive_reg <= ~sDrive_reg;
                    if (sDrive_reg) begin
                        sState_reg <= sRd_reg ? S_TX : S_RX;
                        sBit_reg <= 3'h0;
                        if (sRd_reg) begin
                            sShift_reg <= sTx_reg;
                            sDrive_reg <= ~sTx_reg[7];
                        end
                    end
                end
                S_RX: if (sclRise) begin
                    sShift_reg <= sByteIn;
                    sBit_reg <= sBit_reg + 3'h1;
                    if (sBit_reg == 3'h7) begin
                        sState_reg <= S_ACK;
                        sFirst_reg <= 1'b0;
                    end
                end
                S_TX: if (sclRise) begin
                    sShift_reg <= {sShift_reg[6:0], 1'b0};
                    sBit_reg <= sBit_reg + 3'h1;
                    if (sBit_reg == 3'h7) begin
                        sState_reg <= S_TXACK;
                    end
                end else if (sclFall) begin
                    sDrive_reg <= ~sShift_reg[7];
                end
                S_TXACK: if (sclFall) begin
                    sDrive_reg <= 1'b0;
                end else if (sclRise) begin
                    sState_reg <= sdaS2_reg ? S_IDLE : S_TX;
                    sShift_reg <= sTx_reg;
                    sBit_reg <= 3'h0;
                end
                default: sState_reg <= S_IDLE;
            endcase
        end
    end

    property p_sen_off;
        !ctrl_reg[CTRL_SEN] |=> sState_reg == S_IDLE && !sDrive_reg;
    endproperty
    a_sen_off: assert property (p_sen_off) else $error("Slave runs while disabled.");
    property p_srx;
        sGotByte |=> sRx_reg == $past(sByteIn) && sReq_reg != slave_req_idle;
    endproperty
    a_srx: assert property (p_srx) else $error("Slave byte not stored.");

    // Software registers, interrupt status and pin drivers.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_reg <= RST_CTRL;
            mAddr_reg <= RST_BYTE;
            mTx_reg <= RST_BYTE;
            sOwn_reg <= RST_OWN;
            sTx_reg <= RST_BYTE;
            sRx_reg <= RST_BYTE;
            sReq_reg <= slave_req_idle;
            intRaw_reg <= RST_INT;
            intMask_reg <= RST_INT;
            busBusy_reg <= 1'b0;
            mBusyD_reg <= 1'b0;
            irq_reg <= 1'b0;
            sclOe_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
        end else begin
            if (wr(OFF_CTRL)) ctrl_reg <= hwdata[3:0];
            if (wr(OFF_MADDR)) mAddr_reg <= hwdata[7:0];
            if (wr(OFF_MDATA)) mTx_reg <= hwdata[7:0];
            if (wr(OFF_SADDR)) sOwn_reg <= hwdata[6:0];
            if (wr(OFF_SDATA)) sTx_reg <= hwdata[7:0];
            if (wr(OFF_INTMASK)) intMask_reg <= hwdata[1:0];
            if (sGotByte) sRx_reg <= sByteIn;
            // New events win over a clear that lands in the same cycle.
            intRaw_reg <= (intRaw_reg & ~intW1c) | {sEvent, mDone};
            sReq_reg <= sGotByte ? (sFirst_reg ? slave_req_first_byte : slave_req_receive)
                : sTxReq ? slave_req_transmit
                : (dPend_reg && hit(OFF_SDATA)) ? slave_req_idle : sReq_reg;
            busBusy_reg <= startSeen | (busBusy_reg & ~stopSeen);
            mBusyD_reg <= mBusy;
            irq_reg <= intPend;
            sclOe_reg <= mScl;
            sdaOe_reg <= mSda | sDrive_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        pinLow_reg <= 1'b0;
    end

    property p_done_evt;
        mDone |=> intRaw_reg[INT_MST];
    endproperty
    a_done_evt: assert property (p_done_evt) else $error("No event at end of transfer.");
    property p_clear;
        (intW1c[INT_MST] && !mDone) |=> !intRaw_reg[INT_MST]
            ##1 (!irq_reg || $past(intRaw_reg[INT_SLV] & intMask_reg[INT_SLV]));
    endproperty
    a_clear: assert property (p_clear) else $error("Interrupt clear ignored.");
    property p_raw_keep;
        (intRaw_reg[INT_MST] && !intW1c[INT_MST]) |=> intRaw_reg[INT_MST];
    endproperty
    a_raw_keep: assert property (p_raw_keep) else $error("Raw status lost.");
    property p_mask;
        (intRaw_reg == 2'h1 && intMask_reg == 2'h2) |=> !irq_reg;
    endproperty
    a_mask: assert property (p_mask) else $error("Masked source reached irq.");
    property p_bus_busy;
        startSeen |=> busBusy_reg;
    endproperty
    a_bus_busy: assert property (p_bus_busy) else $error("Bus busy not set.");

    assign hreadyout = hreadyout_reg;
    assign hresp = pinLow_reg;
    assign hrdata = hrdata_reg;
    assign sclOut = pinLow_reg;
    assign sdaOut = pinLow_reg;
    assign sclOe = sclOe_reg;
    assign sdaOe = sdaOe_reg;
    assign irq = irq_reg;
endmodule // ims_i2c_port

// File: ims_far_slave.sv
`timescale 1ns/100ps
module ims_far_slave (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda,
    input wire logic [6:0] myAddr,
    input wire logic [7:0] txByte,
    input wire logic ackData,
    output logic sdaLow,
    output logic [7:0] rxByte,
    output int startCnt
);
    logic sclQ_reg, sdaQ_reg, active_reg, inAddr_reg, rd_reg, hit_reg;
    logic [7:0] shift_reg;
    int bitCnt_reg;
    wire sclRise = scl & ~sclQ_reg;
    wire sclFall = ~scl & sclQ_reg;
    wire startSeen = scl & sclQ_reg & sdaQ_reg & ~sda;
    wire stopSeen = scl & sclQ_reg & ~sdaQ_reg & sda;
    always_ff @(posedge clk_sys) begin
        sclQ_reg <= scl;
        sdaQ_reg <= sda;
        if (srst) begin
            active_reg <= 1'b0;
            sdaLow <= 1'b0;
            startCnt <= 0;
        end else if (stopSeen) begin
            active_reg <= 1'b0;
            sdaLow <= 1'b0;
        end else if (startSeen) begin
            active_reg <= 1'b1;
            inAddr_reg <= 1'b1;
            bitCnt_reg <= 0;
            hit_reg <= 1'b0;
            rd_reg <= 1'b0;
            startCnt <= startCnt + 1;
        end else if (active_reg && sclRise && bitCnt_reg < 9) begin
            if (bitCnt_reg < 8) shift_reg <= {shift_reg[6:0], sda};
            bitCnt_reg <= bitCnt_reg + 1;
        end else if (active_reg && sclFall) begin
            // Data changes only while the clock is low; the pull-up restores released bits.
            if (bitCnt_reg == 8 && inAddr_reg) begin
                hit_reg <= shift_reg[7:1] == myAddr;
                rd_reg <= shift_reg[0];
                sdaLow <= shift_reg[7:1] == myAddr;
            end else if (bitCnt_reg == 8) begin
                sdaLow <= ~rd_reg & hit_reg & ackData;
                if (!rd_reg && hit_reg) rxByte <= shift_reg;
            end else if (bitCnt_reg == 9) begin
                bitCnt_reg <= 0;
                inAddr_reg <= 1'b0;
                // Only the address acknowledge hands over to data; after the master's NACK
                // the line must be free, or the STOP that follows can never be seen.
                sdaLow <= rd_reg & hit_reg & inAddr_reg & ~txByte[7];
            end else if (rd_reg && hit_reg && !inAddr_reg) begin
                sdaLow <= ~txByte[3'(7 - bitCnt_reg)];
            end
        end
    end
endmodule // ims_far_slave

// File: ims_i2c_port_tb_top.sv
`timescale 1ns/100ps
module ims_i2c_port_tb_top;
    import ims_pkg::*;
    logic clk_sys, srst, hsel, hwrite, hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe, irq;
    logic farLow, farAck, sclQ;
    logic [31:0] haddr, hwdata, hrdata, rdData;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [6:0] farAddr;
    logic [7:0] farTx, farRx, b;
    int farStarts, s, failures, n_compared, clkCnt, sclPer;
    int expQ[$];
    // Only the master drives the clock, since the far device never stretches it.
    wire scl = ~sclOe;
    wire sda = ~(sdaOe | farLow);
    ims_i2c_port uut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclIn(scl), .sclOut(sclOut),
        .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
    ims_far_slave far (.clk_sys(clk_sys), .srst(srst), .scl(scl), .sda(sda), .myAddr(farAddr),
        .txByte(farTx), .ackData(farAck), .sdaLow(farLow), .rxByte(farRx), .startCnt(farStarts));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        clkCnt++;
        if (scl && !sclQ) begin
            sclPer = clkCnt;
            clkCnt = 0;
        end
        sclQ = scl;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rdData = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(rdData, exp);
    endtask
    task automatic run(input logic [7:0] maddr, input logic [1:0] err);
        int n;
        bus(1'b1, OFF_MADDR, {24'h000000, maddr});
        bus(1'b1, OFF_MCMD, 32'h00000001);
        rd(OFF_MSTAT, {28'h0000000, 2'b11, err} & 32'h00000004);
        n = 0;
        while (rdData[3:2] !== 2'b00 && n < 4000) begin
            bus(1'b0, OFF_MSTAT, 32'h00000000);
            n++;
        end
        chk({28'h0, rdData[3:0]}, {30'h0, err});
        $display("test transfer to %h done", maddr);
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #4_000_000;
        failures++;
        summarize();
    end
    initial begin
        void'($urandom(32'h975bd401));
        {srst, farAck, sclQ} = 3'b111;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {farAddr, farTx, clkCnt} = '0;
        hsize = 3'b010;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        rd(OFF_CTRL, 32'h0);
        rd(OFF_INTST, 32'h0);
        rd(8'hfc, 32'h0);
        chk({29'h0, hresp, sclOut, sdaOut}, 32'h0);
        $display("test reset done");
        for (int f = 0; f < 2; f++) begin
            farAddr <= 7'($urandom_range(8, 119));
            b = 8'($urandom);
            expQ.push_back(int'(b));
            bus(1'b1, OFF_CTRL, 32'(1 + (f << CTRL_FAST)));
            bus(1'b1, OFF_INTMASK, 32'h1);
            bus(1'b1, OFF_MDATA, {24'h0, b});
            run({1'b0, farAddr}, ERR_NONE);
            chk(32'(farRx), 32'(expQ.pop_front()));
            chk(32'(sclPer), 32'(f ? 4 * QTR_FAST : 4 * QTR_STD));
            rd(OFF_INTST, 32'h1);
            chk(32'(irq), 32'h1);
            bus(1'b1, OFF_INTST, 32'h1);
            farTx <= 8'($urandom);
            run({1'b1, farAddr}, ERR_NONE);
            rd(OFF_MDATA, {24'h0, farTx});
        end
        bus(1'b1, OFF_INTMASK, 32'h0);
        rd(OFF_INTST, 32'h1);
        chk(32'(irq), 32'h0);
        bus(1'b1, OFF_CTRL, 32'h0000000d);
        rd(OFF_INTST, 32'h0);
        bus(1'b1, OFF_INTMASK, 32'h1);
        rd(OFF_INTST, 32'h1);
        chk(32'(irq), 32'h1);
        bus(1'b1, OFF_INTST, 32'h1);
        rd(OFF_INTST, 32'h0);
        chk(32'(irq), 32'h0);
        $display("test interrupt done");
        farAck <= 1'b0;
        run({1'b0, farAddr}, ERR_DATA_ACK);
        farAck <= 1'b1;
        run({1'b0, farAddr ^ 7'h01}, ERR_ADDR_ACK);
        bus(1'b1, OFF_CTRL, 32'h0);
        s = farStarts;
        bus(1'b1, OFF_MCMD, 32'h1);
        repeat (8) @(posedge clk_sys);
        rd(OFF_MSTAT, {30'h0, ERR_ADDR_ACK});
        chk(32'(farStarts), 32'(s));
        $display("test disable done");
        // The block's own slave answers its own master on the shared lines.
        bus(1'b1, OFF_SADDR, {25'h0, farAddr ^ 7'h02});
        bus(1'b1, OFF_CTRL, 32'h3);
        b = 8'($urandom);
        bus(1'b1, OFF_MDATA, {24'h0, b});
        run({1'b0, farAddr ^ 7'h02}, ERR_NONE);
        rd(OFF_SSTAT, {30'h0, slave_req_first_byte});
        rd(OFF_SDATA, {24'h0, b});
        rd(OFF_SSTAT, {30'h0, slave_req_idle});
        b = 8'($urandom);
        bus(1'b1, OFF_SDATA, {24'h0, b});
        run({1'b1, farAddr ^ 7'h02}, ERR_NONE);
        rd(OFF_SSTAT, {30'h0, slave_req_transmit});
        rd(OFF_MDATA, {24'h0, b});
        bus(1'b1, OFF_CTRL, 32'h1);
        run({1'b0, farAddr ^ 7'h02}, ERR_ADDR_ACK);
        $display("test slave done");
        summarize();
    end
endmodule // ims_i2c_port_tb_top
